// ==== tb/pbs_bus_model.sv ====
// Shared data lines as seen by the processor side of the SRAM.
// Assumes at most one party enables its drivers at a time.
module pbs_bus_model (
  input wire logic clk_in,
  input wire logic dev_oe_in,
  input wire logic [31:0] dev_data_in,
  input wire logic host_oe_in,
  input wire logic [31:0] host_data_in,
  output logic [31:0] bus_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] last_ff = 32'h0;
  // Floating lines toggle so stale data never looks valid
  always_comb begin
    if (dev_oe_in) begin
      bus_out = dev_data_in;
    end else if (host_oe_in) begin
      bus_out = host_data_in;
    end else begin
      bus_out = ~last_ff;
    end
  end
  always_ff @(posedge clk_in) begin
    last_ff <= bus_out;
  end
endmodule

// ==== tb/pbs_sram_assertions.sv ====
// Port-level checks on the burst SRAM front end.
// Assumes a bind to pbs_sram_top; one clock, synchronous reset.
module pbs_sram_assertions (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic dq_oe_out,
  input wire logic processor_addr_strobe_n_in,
  input wire logic controller_addr_strobe_n_in,
  input wire logic burst_advance_n_in,
  input wire logic byte_write_enable_n_in,
  input wire logic global_write_n_in,
  input wire logic chip_select_first_n_in,
  input wire logic chip_select_second_in,
  input wire logic chip_select_third_n_in,
  input wire logic output_enable_n_in,
  input wire logic sleep_request_in,
  input wire logic asleep_out,
  input wire logic tck_in,
  input wire logic tdo_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sel;
  logic idle;
  logic rd_go;
  assign sel = !chip_select_first_n_in && chip_select_second_in && !chip_select_third_n_in;
  assign idle = processor_addr_strobe_n_in && controller_addr_strobe_n_in
    && global_write_n_in && byte_write_enable_n_in;
  assign rd_go = sel && !controller_addr_strobe_n_in && processor_addr_strobe_n_in
    && global_write_n_in && byte_write_enable_n_in && !asleep_out;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  AST_OE_GATE: assert property (dq_oe_out |-> !output_enable_n_in)
    else $error("data driven with enable high");
  AST_OE_ASYNC: assert property ($rose(output_enable_n_in) |-> !dq_oe_out)
    else $error("enable acted late");
  // Sleep quiet for three cycles so the synchroniser cannot cut in
  AST_READ:
    assert property ((!sleep_request_in)[*3] ##0 rd_go ##1 idle ##1 !output_enable_n_in
      |-> dq_oe_out) else $error("read not driven");
  AST_BURST:
    assert property ((!sleep_request_in)[*3] ##0 rd_go ##1 (idle && !burst_advance_n_in)[*2]
      ##1 !output_enable_n_in |-> dq_oe_out) else $error("burst not driven");
  AST_DESEL: assert property (!controller_addr_strobe_n_in && !sel |-> ##2 !dq_oe_out)
    else $error("driven after deselect");
  AST_CE1:
    assert property (!controller_addr_strobe_n_in && !sel ##1
      (chip_select_first_n_in && controller_addr_strobe_n_in) |-> ##2 !dq_oe_out)
      else $error("strobe taken with first select high");
  AST_ZZ_IN: assert property (sleep_request_in [*4] |-> asleep_out)
    else $error("sleep not entered");
  AST_ZZ_OUT: assert property ((!sleep_request_in) [*4] |-> !asleep_out)
    else $error("sleep not left");
  AST_ZZ_QUIET: assert property (asleep_out && $past(asleep_out) |-> !dq_oe_out)
    else $error("driven while asleep");
  AST_TDO_FALL: assert property ($changed(tdo_out) |-> !tck_in)
    else $error("scan out moved with test clock high");
endmodule

bind pbs_sram_top pbs_sram_assertions i_chk (.mclk_in, .reset_in, .dq_oe_out,
  .processor_addr_strobe_n_in, .controller_addr_strobe_n_in, .burst_advance_n_in,
  .byte_write_enable_n_in, .global_write_n_in, .chip_select_first_n_in,
  .chip_select_second_in, .chip_select_third_n_in, .output_enable_n_in,
  .sleep_request_in, .asleep_out, .tck_in, .tdo_out);

// ==== tb/test_pbs_sram_top.sv ====
// Self-checking bench for the burst SRAM front end.
// Assumes the bus model resolves the shared data lines.
module test_pbs_sram_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 0, reset_in = 1, burst_order_in = 0, host_oe = 0;
  logic processor_addr_strobe_n_in = 1, controller_addr_strobe_n_in = 1;
  logic burst_advance_n_in = 1, byte_write_enable_n_in = 1, global_write_n_in = 1;
  logic chip_select_first_n_in = 0, chip_select_second_in = 1, chip_select_third_n_in = 0;
  logic output_enable_n_in = 0, sleep_request_in = 0, tck_in = 0, tdi_in = 0, tms_in = 0;
  logic [3:0] byte_select_n_in = 4'hF;
  logic [9:0] addr_in = 10'h000;
  logic [31:0] host_data = 32'h0, dq_in, dq_out;
  logic dq_oe_out, write_ready_out, asleep_out, tdo_out;
  int n_fail = 0, compares = 0;

  initial forever #20 mclk_in = ~mclk_in;

  pbs_sram_top i_dut (.mclk_in, .reset_in, .addr_in, .dq_in, .dq_out, .dq_oe_out,
    .processor_addr_strobe_n_in, .controller_addr_strobe_n_in, .burst_advance_n_in,
    .byte_write_enable_n_in, .byte_select_n_in, .global_write_n_in,
    .chip_select_first_n_in, .chip_select_second_in, .chip_select_third_n_in,
    .output_enable_n_in, .sleep_request_in, .burst_order_in, .write_ready_out,
    .asleep_out, .tck_in, .tdi_in, .tms_in, .tdo_out);
  pbs_bus_model i_bus (.clk_in(mclk_in), .dev_oe_in(dq_oe_out), .dev_data_in(dq_out),
    .host_oe_in(host_oe), .host_data_in(host_data), .bus_out(dq_in));

  task automatic finish_test();
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_sleep(input logic v);
    int i;
    for (i = 0; i < 20 && asleep_out !== v; i++) tick(1);
    if (i == 20) begin
      n_fail++;
      $display("mismatch at %0t: sleep state timeout", $time);
      finish_test();
    end
  endtask

  // Strap only moves while reset is held
  task automatic do_reset(input logic order);
    reset_in = 1;
    burst_order_in = order;
    tick(8);
    chk(32'({dq_oe_out, write_ready_out, asleep_out, tdo_out}), 32'h4);
    reset_in = 0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] b,
      input logic g, input logic e);
    output_enable_n_in = 1;
    host_oe = 1;
    host_data = d;
    {addr_in, byte_select_n_in, global_write_n_in, byte_write_enable_n_in} = {a, b, g, e};
    controller_addr_strobe_n_in = 0;
    tick(1);
    host_oe = 0;
    {controller_addr_strobe_n_in, global_write_n_in, byte_write_enable_n_in} = 3'h7;
    byte_select_n_in = 4'hF;
    tick(2);
    output_enable_n_in = 0;
    chk(32'(write_ready_out), 32'h1);
  endtask

  task automatic rd(input logic p, input logic c, input logic g, input logic [9:0] a,
      input logic [31:0] e);
    {processor_addr_strobe_n_in, controller_addr_strobe_n_in, global_write_n_in} = {p, c, g};
    addr_in = a;
    tick(1);
    {processor_addr_strobe_n_in, controller_addr_strobe_n_in, global_write_n_in} = 3'h7;
    tick(1);
    chk(32'(dq_oe_out), 32'(!output_enable_n_in));
    if (!output_enable_n_in) chk(dq_out, e);
  endtask

  task automatic t_burst(input logic order);
    logic [1:0] s;
    do_reset(order);
    for (int i = 0; i < 4; i++) wr(10'h010 + 10'(i), 32'hA0 + 32'(i), 4'hF, 1'b0, 1'b1);
    // Interleaved pass starts from the controller strobe instead
    {processor_addr_strobe_n_in, controller_addr_strobe_n_in} = {order, !order};
    addr_in = 10'h011;
    tick(1);
    {processor_addr_strobe_n_in, controller_addr_strobe_n_in} = 2'h3;
    burst_advance_n_in = 0;
    tick(1);
    for (int k = 0; k < 7; k++) begin
      s = 2'(k == 6 ? 5 : k);
      s = order ? (2'h1 ^ s) : (2'h1 + s);
      chk(dq_out, 32'hA0 + 32'(s));
      if (k == 4) burst_advance_n_in = 1;
      tick(1);
    end
  endtask

  task automatic t_access();
    wr(10'h040, 32'h1234_5678, 4'hF, 1'b0, 1'b1);
    rd(1'b1, 1'b0, 1'b1, 10'h040, 32'h1234_5678);
    wr(10'h040, 32'hAABB_CCDD, 4'hA, 1'b1, 1'b0);
    wr(10'h040, 32'h0, 4'h0, 1'b1, 1'b1);
    rd(1'b0, 1'b0, 1'b0, 10'h040, 32'h12BB_56DD);
    rd(1'b0, 1'b1, 1'b1, 10'h040, 32'h12BB_56DD);
    output_enable_n_in = 1;
    rd(1'b1, 1'b0, 1'b1, 10'h040, 32'h0);
    output_enable_n_in = 0;
    for (int i = 0; i < 3; i++) begin
      {chip_select_first_n_in, chip_select_second_in, chip_select_third_n_in} =
        3'b010 ^ (3'b100 >> i);
      controller_addr_strobe_n_in = 0;
      tick(1);
      controller_addr_strobe_n_in = 1;
      processor_addr_strobe_n_in = 0;
      chip_select_first_n_in = 1;
      tick(1);
      processor_addr_strobe_n_in = 1;
      {chip_select_first_n_in, chip_select_second_in, chip_select_third_n_in} = 3'b010;
      tick(2);
      chk(32'(dq_oe_out), 32'h0);
    end
  endtask

  task automatic t_sleep();
    sleep_request_in = 1;
    wait_sleep(1'b1);
    controller_addr_strobe_n_in = 0;
    tick(1);
    controller_addr_strobe_n_in = 1;
    tick(1);
    chk(32'(dq_oe_out), 32'h0);
    sleep_request_in = 0;
    wait_sleep(1'b0);
    tick(2);
    rd(1'b0, 1'b1, 1'b1, 10'h040, 32'h12BB_56DD);
  endtask

  // Test clock held several main cycles per level, as the sampler needs
  task automatic t_scan();
    for (int b = 0; b < 2; b++) begin
      tdi_in = (b == 0);
      tick(4);
      tck_in = 1;
      tick(4);
      tdi_in = !tdi_in;
      tick(4);
      chk(32'(tdo_out), 32'(b != 0));
      tck_in = 0;
      tick(6);
      chk(32'(tdo_out), 32'(!tdi_in));
    end
  endtask

  initial begin
    tick(1);
    t_burst(1'b0);
    t_burst(1'b1);
    t_access();
    t_sleep();
    t_scan();
    finish_test();
  end
endmodule

// ==== verilog/pbs_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module pbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] slot_ff [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] count_ff;
  logic push;
  logic pop;

  assign in_ready_out = (count_ff != CNT_FULL);
  assign out_valid_out = (count_ff != '0);
  assign out_data_out = slot_ff[rd_ptr_ff];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      slot_ff[wr_ptr_ff] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == PTR_LAST) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PTR_LAST) ? '0 : rd_ptr_ff + 1'b1;
      end
      case ({push, pop})
        2'b10: count_ff <= count_ff + 1'b1;
        2'b01: count_ff <= count_ff - 1'b1;
        default: count_ff <= count_ff;
      endcase
    end
  end

endmodule

// ==== verilog/pbs_pkg.sv ====
// Constants and types for the pipelined burst SRAM front end.
// Assumes a single 25 MHz clock and a synchronous active-high reset.
// Overview of operation
// - Strap low selects linear burst order
// - Strap high selects interleaved; an open strap holds the burst at its start
// - Scan output changes on test clock fall
// - Scan inputs sampled on test clock rise
// - All synchronous inputs registered on rise
// - Read data leaves through output registers
// - Either address strobe starts an access
// - Advance input steps burst, else hold
// - Two-bit wraparound burst counter from start
// - Byte writes only on selected bytes
// - Global write stores all four bytes
// - Selected only when all three selects active
// - Processor strobe ignored when first select high
// - Burst order fixed by sampled strap
// - Processor strobe wins; strobes load counter
// - Data pins driven only while enable low
// - Read data follows previously captured address
// - Sleep input idles device, keeps contents
package pbs_pkg;

  localparam int ADDR_W = 10;
  localparam int MEM_DEPTH = 1024;
  localparam int BYTE_W = 8;
  localparam int NUM_BYTES = 4;
  localparam int DATA_W = BYTE_W * NUM_BYTES;
  localparam int BURST_W = 2;
  localparam int FIFO_DEPTH = 4;
  localparam int WR_W = ADDR_W + NUM_BYTES + DATA_W;

  localparam logic ORDER_LINEAR = 1'b0;
  localparam logic ORDER_INTERLEAVED = 1'b1;
  localparam logic [BURST_W-1:0] BURST_STEP_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP_ONE = 2'h1;
  localparam logic [NUM_BYTES-1:0] BYTES_ALL = 4'hF;
  localparam logic [NUM_BYTES-1:0] BYTES_NONE = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 10'h000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    PBS_DESELECTED = 2'b00,
    PBS_ACTIVE = 2'b01,
    PBS_SLEEP = 2'b10
  } pbs_state_t;

endpackage

// ==== verilog/pbs_sram_top.sv ====
// Pipelined burst SRAM: registered inputs, burst counter, byte writes,
// pipelined reads and a minimal boundary-scan bypass path.
// Assumes inputs other than sleep and output enable are synchronous to mclk_in; test clock is sampled.
module pbs_sram_top (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [pbs_pkg::ADDR_W-1:0] addr_in,
  input wire logic [pbs_pkg::DATA_W-1:0] dq_in,
  output logic [pbs_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_out,
  input wire logic processor_addr_strobe_n_in,
  input wire logic controller_addr_strobe_n_in,
  input wire logic burst_advance_n_in,
  input wire logic byte_write_enable_n_in,
  input wire logic [pbs_pkg::NUM_BYTES-1:0] byte_select_n_in,
  input wire logic global_write_n_in,
  input wire logic chip_select_first_n_in,
  input wire logic chip_select_second_in,
  input wire logic chip_select_third_n_in,
  input wire logic output_enable_n_in,
  input wire logic sleep_request_in,
  input wire logic burst_order_in,
  output logic write_ready_out,
  output logic asleep_out,
  input wire logic tck_in,
  input wire logic tdi_in,
  input wire logic tms_in,
  output logic tdo_out
);

  // Registered copies of every synchronous input
  logic [pbs_pkg::ADDR_W-1:0] addr_ff;
  logic [pbs_pkg::DATA_W-1:0] wdata_ff;
  logic proc_strobe_n_ff;
  logic ctrl_strobe_n_ff;
  logic advance_n_ff;
  logic byte_we_n_ff;
  logic [pbs_pkg::NUM_BYTES-1:0] byte_sel_n_ff;
  logic global_write_n_ff;
  logic cs_first_n_ff;
  logic cs_second_ff;
  logic cs_third_n_ff;

  // Sleep synchroniser and the sampled strap
  logic sleep_meta_ff;
  logic sleep_sync_ff;
  logic order_ff;

  // Access state and burst counter
  pbs_pkg::pbs_state_t state_ff;
  pbs_pkg::pbs_state_t nxt_state;
  logic [pbs_pkg::ADDR_W-1:0] base_addr_ff;
  logic [pbs_pkg::BURST_W-1:0] burst_start_ff;
  logic [pbs_pkg::BURST_W-1:0] burst_step_ff;
  logic first_proc_cycle_ff;

  // Read pipeline and the write path
  logic [pbs_pkg::DATA_W-1:0] rdata_ff;
  logic drive_ff;
  logic write_ready_ff;
  logic [pbs_pkg::DATA_W-1:0] mem [pbs_pkg::MEM_DEPTH];

  // Test clock sampling
  logic tck_ff;
  logic tck_prev_ff;
  logic tdi_ff;
  logic tms_ff;
  logic bypass_ff;
  logic tdo_ff;

  // Decode of the registered cycle
  logic selected;
  logic proc_start;
  logic ctrl_start;
  logic start;
  logic active_now;
  logic [pbs_pkg::BURST_W-1:0] cur_step;
  logic [pbs_pkg::BURST_W-1:0] cur_low;
  logic [pbs_pkg::ADDR_W-1:0] cur_addr;
  logic [pbs_pkg::NUM_BYTES-1:0] wr_bytes;
  logic write_cycle;
  logic read_cycle;

  // FIFO connections
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [pbs_pkg::WR_W-1:0] fifo_in_data;
  logic [pbs_pkg::WR_W-1:0] fifo_out_data;
  logic [pbs_pkg::ADDR_W-1:0] drain_addr;
  logic [pbs_pkg::NUM_BYTES-1:0] drain_bytes;
  logic [pbs_pkg::DATA_W-1:0] drain_data;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      addr_ff <= pbs_pkg::ADDR_ZERO;
      wdata_ff <= pbs_pkg::DATA_ZERO;
      proc_strobe_n_ff <= 1'b1;
      ctrl_strobe_n_ff <= 1'b1;
      advance_n_ff <= 1'b1;
      byte_we_n_ff <= 1'b1;
      byte_sel_n_ff <= pbs_pkg::BYTES_ALL;
      global_write_n_ff <= 1'b1;
      cs_first_n_ff <= 1'b1;
      cs_second_ff <= 1'b0;
      cs_third_n_ff <= 1'b1;
    end else begin
      addr_ff <= addr_in;
      wdata_ff <= dq_in;
      proc_strobe_n_ff <= processor_addr_strobe_n_in;
      ctrl_strobe_n_ff <= controller_addr_strobe_n_in;
      advance_n_ff <= burst_advance_n_in;
      byte_we_n_ff <= byte_write_enable_n_in;
      byte_sel_n_ff <= byte_select_n_in;
      global_write_n_ff <= global_write_n_in;
      cs_first_n_ff <= chip_select_first_n_in;
      cs_second_ff <= chip_select_second_in;
      cs_third_n_ff <= chip_select_third_n_in;
    end
  end

  // Sleep is asynchronous to the clock, so it gets two stages
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sleep_meta_ff <= 1'b0;
      sleep_sync_ff <= 1'b0;
    end else begin
      sleep_meta_ff <= sleep_request_in;
      sleep_sync_ff <= sleep_meta_ff;
    end
  end

  // Strap caught while reset is held; the system must not move it later
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      order_ff <= burst_order_in;
    end
  end

  assign selected = ~cs_first_n_ff & cs_second_ff & ~cs_third_n_ff;
  assign proc_start = ~proc_strobe_n_ff & ~cs_first_n_ff;
  assign ctrl_start = ~ctrl_strobe_n_ff & ~proc_start;
  assign start = (proc_start | ctrl_start) & ~sleep_sync_ff;
  assign active_now = start ? selected : (state_ff == pbs_pkg::PBS_ACTIVE);

  // Step moves only on a sampled advance; otherwise the address holds
  assign cur_step = start ? pbs_pkg::BURST_STEP_ZERO :
                    (~advance_n_ff ? burst_step_ff + pbs_pkg::BURST_STEP_ONE :
                     burst_step_ff);

  always_comb begin
    cur_low = burst_start_ff;
    case (order_ff)
      pbs_pkg::ORDER_LINEAR: cur_low = burst_start_ff + cur_step;
      pbs_pkg::ORDER_INTERLEAVED: cur_low = burst_start_ff ^ cur_step;
      default: cur_low = burst_start_ff;
    endcase
  end

  assign cur_addr = start ? addr_ff :
                    {base_addr_ff[pbs_pkg::ADDR_W-1:pbs_pkg::BURST_W], cur_low};

  // Global write overrides the byte qualifiers
  always_comb begin
    if (~global_write_n_ff) begin
      wr_bytes = pbs_pkg::BYTES_ALL;
    end else if (~byte_we_n_ff) begin
      wr_bytes = ~byte_sel_n_ff;
    end else begin
      wr_bytes = pbs_pkg::BYTES_NONE;
    end
  end

  // A processor-strobe start ignores write controls in its first cycle
  assign write_cycle = active_now & ~(start & proc_start) &
                       (wr_bytes != pbs_pkg::BYTES_NONE) & ~sleep_sync_ff;
  assign read_cycle = active_now & ~write_cycle & ~sleep_sync_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pbs_pkg::PBS_DESELECTED: begin
        if (sleep_sync_ff) begin
          nxt_state = pbs_pkg::PBS_SLEEP;
        end else if (start & selected) begin
          nxt_state = pbs_pkg::PBS_ACTIVE;
        end
      end
      pbs_pkg::PBS_ACTIVE: begin
        if (sleep_sync_ff) begin
          nxt_state = pbs_pkg::PBS_SLEEP;
        end else if (start & ~selected) begin
          nxt_state = pbs_pkg::PBS_DESELECTED;
        end
      end
      pbs_pkg::PBS_SLEEP: begin
        if (~sleep_sync_ff) begin
          nxt_state = pbs_pkg::PBS_DESELECTED;
        end
      end
      default: nxt_state = pbs_pkg::PBS_DESELECTED;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_ff <= pbs_pkg::PBS_DESELECTED;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      base_addr_ff <= pbs_pkg::ADDR_ZERO;
      burst_start_ff <= pbs_pkg::BURST_STEP_ZERO;
      burst_step_ff <= pbs_pkg::BURST_STEP_ZERO;
      first_proc_cycle_ff <= 1'b0;
    end else begin
      if (start) begin
        base_addr_ff <= addr_ff;
        burst_start_ff <= addr_ff[pbs_pkg::BURST_W-1:0];
        burst_step_ff <= pbs_pkg::BURST_STEP_ZERO;
      end else if (active_now) begin
        burst_step_ff <= cur_step;
      end
      first_proc_cycle_ff <= start & proc_start;
    end
  end

  // Read data lands in the output register one edge after the address
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rdata_ff <= pbs_pkg::DATA_ZERO;
    end else if (read_cycle) begin
      rdata_ff <= mem[cur_addr];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= read_cycle; // Writes and deselects tri-state at once
    end
  end

  assign dq_out = rdata_ff;
  // Enable gates drivers directly so the pins float without a clock edge
  assign dq_oe_out = drive_ff & ~output_enable_n_in;

  // Writes queue in the FIFO; sleep stops the drain and new writes alike, so it never holds more than one
  assign fifo_in_data = {cur_addr, wr_bytes, wdata_ff};
  assign fifo_out_ready = ~sleep_sync_ff;
  assign drain_addr = fifo_out_data[pbs_pkg::WR_W-1 -: pbs_pkg::ADDR_W];
  assign drain_bytes = fifo_out_data[pbs_pkg::DATA_W +: pbs_pkg::NUM_BYTES];
  assign drain_data = fifo_out_data[pbs_pkg::DATA_W-1:0];

  pbs_fifo #(
    .WIDTH(pbs_pkg::WR_W),
    .DEPTH(pbs_pkg::FIFO_DEPTH)
  ) u_write_fifo (
    .clk_in(mclk_in),
    .reset_in(reset_in),
    .in_valid_in(write_cycle),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_in_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data)
  );

  // Unselected lanes keep their old bytes
  always_ff @(posedge mclk_in) begin
    if (fifo_out_valid & fifo_out_ready) begin
      for (int b = 0; b < pbs_pkg::NUM_BYTES; b++) begin
        if (drain_bytes[b]) begin
          mem[drain_addr][b*pbs_pkg::BYTE_W +: pbs_pkg::BYTE_W] <=
            drain_data[b*pbs_pkg::BYTE_W +: pbs_pkg::BYTE_W];
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      write_ready_ff <= 1'b1;
    end else begin
      write_ready_ff <= fifo_in_ready;
    end
  end

  assign write_ready_out = write_ready_ff;
  assign asleep_out = (state_ff == pbs_pkg::PBS_SLEEP);

  // Test clock is slow against mclk_in, so edges are found by sampling
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      tck_ff <= 1'b0;
      tck_prev_ff <= 1'b0;
      tdi_ff <= 1'b0;
      tms_ff <= 1'b1;
    end else begin
      tck_ff <= tck_in;
      tck_prev_ff <= tck_ff;
      tdi_ff <= tdi_in;
      tms_ff <= tms_in;
    end
  end

  // Only the one-bit bypass path; no full test state machine
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      bypass_ff <= 1'b0;
    end else if (tck_ff & ~tck_prev_ff & ~tms_ff) begin
      bypass_ff <= tdi_ff;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      tdo_ff <= 1'b0;
    end else if (~tck_ff & tck_prev_ff) begin
      tdo_ff <= bypass_ff;
    end
  end

  assign tdo_out = tdo_ff;

endmodule
